// ---- logic/sclm_cfg.svh ----
// Constants for the strap latch and clock-request pin multiplexer
//
// Contract
// - Pin 1 drives PCI clock 0 after power-up
// - Disabled PCI clock output leaves pin undriven
// - Byte 5 bit 7 picks pin 1 function
// - Request A gates pair 0 or pair 2
// - Byte 5 bit 5 picks pin 3 function
// - Byte 5 bit 4 routes request B
// - Sample trusted-mode strap on pin 4 at power-up
// - Pin 4 drives PCI clock 2 after sampling
// - Latch pin 6 video strap, then drive PCI
// - Video strap 1 means SRC, 0 means display
// - Free-running PCI clock ignores the stop input
// - Pin 7 debug strap picks shared pair use
`ifndef SCLM_CFG_SVH
`define SCLM_CFG_SVH

// ----------------------------------------
// Pin slots on the shared pin vector
// ----------------------------------------
`define SCLM_NPINS 5
`define SCLM_SLOT_PIN1 0
`define SCLM_SLOT_PIN3 1
`define SCLM_SLOT_PIN4 2
`define SCLM_SLOT_PIN6 3
`define SCLM_SLOT_PIN7 4

// ----------------------------------------
// Configuration byte bit positions
// ----------------------------------------
`define SCLM_B2_PCI_CLOCK_OUT_0_EN 0
`define SCLM_B2_PCI_CLOCK_OUT_1_EN 1
`define SCLM_B2_PCI2_EN 2
`define SCLM_B2_PCI4_EN 4
`define SCLM_B2_PCIF5_EN 5
`define SCLM_B5_CRA_EN 7
`define SCLM_B5_CRA_SEL 6
`define SCLM_B5_CRB_EN 5
`define SCLM_B5_CRB_SEL 4

// ----------------------------------------
// Reset values and strap settle timing
// ----------------------------------------
`define SCLM_PIN_RST 5'h00
`define SCLM_GATE_RST 4'hf
`define SCLM_CLK_NS 10
`define SCLM_SETTLE_NS 100
`define SCLM_SETTLE_CYC ((`SCLM_SETTLE_NS + `SCLM_CLK_NS - 1) / `SCLM_CLK_NS)
`define SCLM_CNT_W 8

`endif

// ---- logic/sclm_pkg.sv ----
// Types for the strap latch and clock-request pin multiplexer
package sclm_pkg;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [0:0] {
        ST_SETTLE,
        ST_RUN
    } sclm_state_e;

    // ----------------------------------------
    // Latched straps
    // ----------------------------------------
    typedef struct packed {
        logic trusted_mode_strap;
        logic video_strap;
        logic debug_pair_strap;
    } sclm_strap_s;

    // ----------------------------------------
    // Run enables of the gated SRC pairs
    // ----------------------------------------
    typedef struct packed {
        logic serial_ref_pair_4;
        logic serial_ref_pair_2;
        logic serial_ref_pair_1;
        logic serial_ref_pair_0;
    } sclm_src_gate_s;

endpackage

// ---- logic/sclm_top.sv ----
// Power-up strap latch and PCI clock / clock-request pin multiplexer
`timescale 1ns/1ps
`include "sclm_cfg.svh"

module sclm_top #(
    parameter int SETTLE_CYC = `SCLM_SETTLE_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [`SCLM_NPINS-1:0] i_pin_in,
    input wire logic i_pci_phase,
    input wire logic i_pci_stop_n,
    input wire logic [7:0] i_cfg_byte2,
    input wire logic [7:0] i_cfg_byte5,
    output logic [`SCLM_NPINS-1:0] o_pin_out,
    output logic [`SCLM_NPINS-1:0] o_pin_oe,
    output sclm_pkg::sclm_src_gate_s o_src_gate,
    output sclm_pkg::sclm_strap_s o_strap,
    output logic o_overclock_allowed,
    output logic o_shared_pair_is_src,
    output logic o_shared_pair_is_debug,
    output logic o_strap_done
);

    // ----------------------------------------
    // Pin and stop synchronisers
    // ----------------------------------------
    logic [`SCLM_NPINS-1:0] meta_q;
    logic [`SCLM_NPINS-1:0] pin_q;
    logic stop_meta_q;
    logic stop_n_q;

    genvar g;
    generate
        for (g = 0; g < `SCLM_NPINS; g++) begin : g_sync
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    meta_q[g] <= 1'b0;
                    pin_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= i_pin_in[g];
                    pin_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            stop_meta_q <= 1'b1;
            stop_n_q <= 1'b1;
        end else begin
            stop_meta_q <= i_pci_stop_n;
            stop_n_q <= stop_meta_q;
        end
    end

    // ----------------------------------------
    // Strap sequencer
    // ----------------------------------------
    // Pins stay undriven while the straps settle; a driven pin would
    // fight the strap resistor and corrupt the sampled level.
    sclm_pkg::sclm_state_e state_q;
    sclm_pkg::sclm_state_e state_d;
    logic [`SCLM_CNT_W-1:0] cnt_q;
    logic [`SCLM_CNT_W-1:0] cnt_d;
    sclm_pkg::sclm_strap_s strap_q;
    sclm_pkg::sclm_strap_s strap_d;
    logic latch_now;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        strap_d = strap_q;
        latch_now = 1'b0;
        case (state_q)
            sclm_pkg::ST_SETTLE: begin
                if (cnt_q >= `SCLM_CNT_W'(SETTLE_CYC - 1)) begin
                    latch_now = 1'b1;
                    strap_d.trusted_mode_strap = pin_q[`SCLM_SLOT_PIN4];
                    strap_d.video_strap = pin_q[`SCLM_SLOT_PIN6];
                    strap_d.debug_pair_strap = pin_q[`SCLM_SLOT_PIN7];
                    state_d = sclm_pkg::ST_RUN;
                end else begin
                    cnt_d = cnt_q + `SCLM_CNT_W'(1);
                end
            end
            sclm_pkg::ST_RUN: begin
                // No path back: straps hold until the next reset
                state_d = sclm_pkg::ST_RUN;
            end
            default: begin
                state_d = sclm_pkg::ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= sclm_pkg::ST_SETTLE;
            cnt_q <= '0;
            strap_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            strap_q <= strap_d;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic run;
    logic cra_en;
    logic cra_sel;
    logic crb_en;
    logic crb_sel;
    logic [`SCLM_NPINS-1:0] pci_en;
    logic [`SCLM_NPINS-1:0] stoppable;
    logic [`SCLM_NPINS-1:0] oe_d;
    logic [`SCLM_NPINS-1:0] out_d;
    logic [`SCLM_NPINS-1:0] oe_q;
    logic [`SCLM_NPINS-1:0] out_q;

    assign run = (state_q == sclm_pkg::ST_RUN);
    assign cra_en = i_cfg_byte5[`SCLM_B5_CRA_EN];
    assign cra_sel = i_cfg_byte5[`SCLM_B5_CRA_SEL];
    assign crb_en = i_cfg_byte5[`SCLM_B5_CRB_EN];
    assign crb_sel = i_cfg_byte5[`SCLM_B5_CRB_SEL];
    assign pci_en = {i_cfg_byte2[`SCLM_B2_PCIF5_EN], i_cfg_byte2[`SCLM_B2_PCI4_EN],
                     i_cfg_byte2[`SCLM_B2_PCI2_EN], i_cfg_byte2[`SCLM_B2_PCI_CLOCK_OUT_1_EN],
                     i_cfg_byte2[`SCLM_B2_PCI_CLOCK_OUT_0_EN]};
    // Free-running output on pin 7 is never stopped
    assign stoppable = 5'h0f;

    always_comb begin
        oe_d = '0;
        out_d = '0;
        for (int i = 0; i < `SCLM_NPINS; i++) begin
            // Disabled or idle output leaves the pin undriven
            oe_d[i] = run & pci_en[i];
        end
        // Request inputs take the pin away from the PCI driver
        if (cra_en) begin
            oe_d[`SCLM_SLOT_PIN1] = 1'b0;
        end
        if (crb_en) begin
            oe_d[`SCLM_SLOT_PIN3] = 1'b0;
        end
        for (int i = 0; i < `SCLM_NPINS; i++) begin
            out_d[i] = oe_d[i] & i_pci_phase & (stop_n_q | ~stoppable[i]);
        end
    end

    // Default PCI drive on every shared pin once straps are
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            oe_q <= `SCLM_PIN_RST;
            out_q <= `SCLM_PIN_RST;
        end else begin
            oe_q <= oe_d;
            out_q <= out_d;
        end
    end

    // ----------------------------------------
    // Clock-request gating
    // ----------------------------------------
    // Requests are active low; a pin held high stops its pair.
    sclm_pkg::sclm_src_gate_s gate_d;
    sclm_pkg::sclm_src_gate_s gate_q;
    logic req_a_off;
    logic req_b_off;

    always_comb begin
        req_a_off = run & cra_en & pin_q[`SCLM_SLOT_PIN1];
        req_b_off = run & crb_en & pin_q[`SCLM_SLOT_PIN3];
        gate_d.serial_ref_pair_0 = ~(req_a_off & ~cra_sel);
        gate_d.serial_ref_pair_2 = ~(req_a_off & cra_sel);
        gate_d.serial_ref_pair_1 = ~(req_b_off & ~crb_sel);
        gate_d.serial_ref_pair_4 = ~(req_b_off & crb_sel);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            gate_q <= `SCLM_GATE_RST;
        end else begin
            gate_q <= gate_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_pin_out = out_q;
    assign o_pin_oe = oe_q;
    assign o_src_gate = gate_q;
    assign o_strap = strap_q;
    assign o_strap_done = run;
    assign o_overclock_allowed = ~strap_q.trusted_mode_strap;
    assign o_shared_pair_is_src = strap_q.video_strap;
    assign o_shared_pair_is_debug = strap_q.debug_pair_strap;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    strap_hold_a: assert property (run && $past(run) |-> $stable(strap_q))
        else $error("latched straps changed after power-up");

    pin1_default_a: assert property (
        run && i_cfg_byte2[`SCLM_B2_PCI_CLOCK_OUT_0_EN] && !cra_en |=> o_pin_oe[`SCLM_SLOT_PIN1])
        else $error("pin 1 not driving PCI clock 0");

    disabled_hiz_a: assert property (
        !i_cfg_byte2[`SCLM_B2_PCI2_EN] |=> !o_pin_oe[`SCLM_SLOT_PIN4])
        else $error("disabled PCI output still driven");

    clkreq_a_pin_a: assert property (cra_en |=> !o_pin_oe[`SCLM_SLOT_PIN1])
        else $error("pin 1 driven while request A enabled");

    clkreq_b_pin_a: assert property (crb_en |=> !o_pin_oe[`SCLM_SLOT_PIN3])
        else $error("pin 3 driven while request B enabled");

    route_a_a: assert property (run && cra_en && pin_q[`SCLM_SLOT_PIN1] |=>
        (o_src_gate.serial_ref_pair_0 == $past(cra_sel)) &&
        (o_src_gate.serial_ref_pair_2 == !$past(cra_sel)))
        else $error("request A gated the wrong pair");

    route_b_a: assert property (run && crb_en && pin_q[`SCLM_SLOT_PIN3] |=>
        (o_src_gate.serial_ref_pair_1 == $past(crb_sel)) &&
        (o_src_gate.serial_ref_pair_4 == !$past(crb_sel)))
        else $error("request B gated the wrong pair");

    strap_sample_a: assert property (latch_now |=>
        o_overclock_allowed == !$past(pin_q[`SCLM_SLOT_PIN4]) &&
        o_shared_pair_is_src == $past(pin_q[`SCLM_SLOT_PIN6]) &&
        o_shared_pair_is_debug == $past(pin_q[`SCLM_SLOT_PIN7]))
        else $error("strap sampled wrong value");

    settle_hiz_a: assert property (!run |=> o_pin_oe == 5'h00)
        else $error("shared pin driven during strap settle");

    pin4_drive_a: assert property (
        run && i_cfg_byte2[`SCLM_B2_PCI2_EN] |=> o_pin_oe[`SCLM_SLOT_PIN4])
        else $error("pin 4 not driving PCI clock 2");

    free_run_a: assert property (
        run && i_cfg_byte2[`SCLM_B2_PCIF5_EN] && !stop_n_q |=>
        o_pin_out[`SCLM_SLOT_PIN7] == $past(i_pci_phase))
        else $error("free-running PCI clock stopped");

    latch_cover_c: cover property (latch_now ##1 run);
    req_a_stop_c: cover property (run && cra_en && cra_sel && pin_q[`SCLM_SLOT_PIN1]);
    req_b_stop_c: cover property (run && crb_en && crb_sel && pin_q[`SCLM_SLOT_PIN3]);
    pci_stop_c: cover property (run && !stop_n_q && o_pin_oe[`SCLM_SLOT_PIN7]);

endmodule

// ---- sim/sclm_board.sv ----
// Board model: strap resistors and request sources on the shared pins
`timescale 1ns/1ps
`include "sclm_cfg.svh"

module sclm_board (
    input wire logic [`SCLM_NPINS-1:0] i_level,
    input wire logic [`SCLM_NPINS-1:0] i_pin_out,
    input wire logic [`SCLM_NPINS-1:0] i_pin_oe,
    output logic [`SCLM_NPINS-1:0] o_pin_in
);
    // ----------------------------------------
    // Wire resolution
    // ----------------------------------------
    // Device wins where it drives; otherwise the board level shows
    // Strap resistors hold straps from power-up onward
    // Requests drive only once the host has freed the pin
    always_comb begin
        for (int k = 0; k < `SCLM_NPINS; k++) begin
            o_pin_in[k] = i_pin_oe[k] ? i_pin_out[k] : i_level[k];
        end
    end
endmodule

// ---- sim/strap_latch_and_clkreq_mux_bench.sv ----
// Testbench for the strap latch and clock-request pin multiplexer
`timescale 1ns/1ps
`include "sclm_cfg.svh"

module strap_latch_and_clkreq_mux_bench;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_pci_phase = 1'b0;
    logic i_pci_stop_n = 1'b1;
    logic [7:0] i_cfg_byte2 = 8'h37;
    logic [7:0] i_cfg_byte5 = 8'h00;
    logic [`SCLM_NPINS-1:0] level = 5'h17;
    logic [`SCLM_NPINS-1:0] pin_in;
    logic [`SCLM_NPINS-1:0] pin_out;
    logic [`SCLM_NPINS-1:0] pin_oe;
    sclm_pkg::sclm_src_gate_s src_gate;
    sclm_pkg::sclm_strap_s strap;
    logic oc_ok;
    logic pair_src;
    logic pair_dbg;
    logic done;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] b5_tab [4] = '{8'h80, 8'hc0, 8'h20, 8'h30};
    logic [7:0] gate_tab [4] = '{8'h0e, 8'h0b, 8'h0d, 8'h07};

    // Short settle keeps the run small; still meets the synchroniser need
    sclm_top #(.SETTLE_CYC(3)) sclm_top_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_pin_in(pin_in),
        .i_pci_phase(i_pci_phase), .i_pci_stop_n(i_pci_stop_n),
        .i_cfg_byte2(i_cfg_byte2), .i_cfg_byte5(i_cfg_byte5),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_src_gate(src_gate),
        .o_strap(strap), .o_overclock_allowed(oc_ok),
        .o_shared_pair_is_src(pair_src), .o_shared_pair_is_debug(pair_dbg),
        .o_strap_done(done)
    );

    sclm_board sclm_board_i (
        .i_level(level), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_pin_in(pin_in)
    );

    always #5 i_clock = ~i_clock;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under 200 cycles
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        wait_cyc(2);
        i_rst = 1'b0;
        for (int k = 0; k < 20 && done !== 1'b1; k++) begin
            wait_cyc(1);
        end
        check("strap_done", {7'h0, done}, 8'h01);
        check("strap", {5'h0, strap}, 8'h05);
        check("overclock", {7'h0, oc_ok}, 8'h00);
        check("pair_src", {7'h0, pair_src}, 8'h00);
        check("pair_dbg", {7'h0, pair_dbg}, 8'h01);
        $display("test straps done");

        wait_cyc(2);
        check("pin_oe", {3'h0, pin_oe}, 8'h1f);
        i_pci_stop_n = 1'b0;
        wait_cyc(4);
        for (int p = 0; p < 2; p++) begin
            i_pci_phase = ~p[0];
            wait_cyc(1);
            check("free_pci", {7'h0, pin_out[4]}, {7'h0, ~p[0]});
            check("stopped_pci", {4'h0, pin_out[3:0]}, 8'h00);
        end
        $display("test pin defaults done");

        i_cfg_byte2 = 8'h00;
        wait_cyc(2);
        check("pin_oe_off", {3'h0, pin_oe}, 8'h00);
        level = 5'h0b;
        wait_cyc(4);
        check("strap_hold", {5'h0, strap}, 8'h05);
        $display("test release done");

        // Host frees both pins before enabling requests
        i_cfg_byte2 = 8'h34;
        for (int i = 0; i < 4; i++) begin
            level[1:0] = 2'b00;
            i_cfg_byte5 = b5_tab[i];
            wait_cyc(4);
            check("gate_held", {4'h0, src_gate}, 8'h0f);
            level[1:0] = 2'b11;
            wait_cyc(4);
            check("gate_req", {4'h0, src_gate}, gate_tab[i]);
        end
        $display("test requests done");

        // Second power-up with the opposite strap levels
        i_cfg_byte2 = 8'h37;
        i_cfg_byte5 = 8'h00;
        level = 5'h08;
        i_rst = 1'b1;
        wait_cyc(2);
        i_rst = 1'b0;
        wait_cyc(2);
        check("settle_done", {7'h0, done}, 8'h00);
        check("settle_oe", {3'h0, pin_oe}, 8'h00);
        for (int k = 0; k < 20 && done !== 1'b1; k++) begin
            wait_cyc(1);
        end
        check("strap_2", {5'h0, strap}, 8'h02);
        check("overclock_2", {7'h0, oc_ok}, 8'h01);
        check("pair_src_2", {7'h0, pair_src}, 8'h01);
        check("pair_dbg_2", {7'h0, pair_dbg}, 8'h00);
        $display("test second power-up done");
        print_verdict();
    end
endmodule
